// *** include/rosm_params.svh ***
`ifndef ROSM_PARAMS_SVH
`define ROSM_PARAMS_SVH
// ==========================================
// timing
`define ROSM_CLK_NS 20
`define ROSM_LOCK_NS 2000
`define ROSM_LOCK_CYCLES ((`ROSM_LOCK_NS + `ROSM_CLK_NS - 1) / `ROSM_CLK_NS)
`define ROSM_LOCK_W 7
// ==========================================
// pins
`define ROSM_GPIO_N 4
`endif

// *** include/rosm_pkg.sv ***
package rosm_pkg;
  typedef enum logic [2:0] {
    ROSM_SHUTDOWN, ROSM_READY, ROSM_LOCK, ROSM_TX, ROSM_RX, ROSM_SLEEP, ROSM_STANDBY
  } rosm_state_t;
  typedef enum logic [2:0] {
    ROSM_CMD_READY, ROSM_CMD_LOCK, ROSM_CMD_TX, ROSM_CMD_RX, ROSM_CMD_SLEEP, ROSM_CMD_STANDBY
  } rosm_cmd_t;
endpackage : rosm_pkg

// *** include/rosm_cmd_if.sv ***
interface rosm_cmd_if;
  import rosm_pkg::*;
  logic cmdValid;
  rosm_cmd_t cmdCode;
  rosm_state_t curState;
  logic accept;
  rosm_state_t nextState;
  rosm_state_t pendState;
  modport ctrl (output cmdValid, output cmdCode, output curState,
                input accept, input nextState, input pendState);
  modport dec (input cmdValid, input cmdCode, input curState,
               output accept, output nextState, output pendState);
endinterface : rosm_cmd_if

// *** core/rosm_cmd_decode.sv ***
module rosm_cmd_decode (
  rosm_cmd_if.dec cmd
);
  import rosm_pkg::*;

  // ==========================================
  // transition table: {accept, next, pending target}
  function automatic logic [6:0] decode(input rosm_state_t st, input rosm_cmd_t c);
    logic [6:0] r;
    r = {1'b0, ROSM_SHUTDOWN, ROSM_LOCK};
    unique case (st)
      ROSM_READY: begin
        unique case (c)
          ROSM_CMD_LOCK: r = {1'b1, ROSM_LOCK, ROSM_LOCK};
          ROSM_CMD_TX: r = {1'b1, ROSM_LOCK, ROSM_TX};
          ROSM_CMD_RX: r = {1'b1, ROSM_LOCK, ROSM_RX};
          ROSM_CMD_SLEEP: r = {1'b1, ROSM_SLEEP, ROSM_LOCK};
          ROSM_CMD_STANDBY: r = {1'b1, ROSM_STANDBY, ROSM_LOCK};
          default: r = {1'b0, ROSM_SHUTDOWN, ROSM_LOCK};
        endcase
      end
      ROSM_LOCK: begin
        unique case (c)
          ROSM_CMD_TX: r = {1'b1, ROSM_TX, ROSM_LOCK};
          ROSM_CMD_RX: r = {1'b1, ROSM_RX, ROSM_LOCK};
          ROSM_CMD_READY: r = {1'b1, ROSM_READY, ROSM_LOCK};
          default: r = {1'b0, ROSM_SHUTDOWN, ROSM_LOCK};
        endcase
      end
      ROSM_TX, ROSM_RX: begin
        unique case (c)
          // the opposite mode goes back through lock
          ROSM_CMD_TX: r = (st == ROSM_RX) ? {1'b1, ROSM_LOCK, ROSM_TX} : r;
          ROSM_CMD_RX: r = (st == ROSM_TX) ? {1'b1, ROSM_LOCK, ROSM_RX} : r;
          ROSM_CMD_LOCK: r = {1'b1, ROSM_LOCK, ROSM_LOCK};
          ROSM_CMD_READY: r = {1'b1, ROSM_READY, ROSM_LOCK};
          default: r = {1'b0, ROSM_SHUTDOWN, ROSM_LOCK};
        endcase
      end
      ROSM_SLEEP, ROSM_STANDBY: r = (c == ROSM_CMD_READY) ? {1'b1, ROSM_READY, ROSM_LOCK} : r;
      default: r = {1'b0, ROSM_SHUTDOWN, ROSM_LOCK};
    endcase
    return r;
  endfunction : decode

  wire [6:0] decWord = decode(cmd.curState, cmd.cmdCode);

  // unlisted pairs are refused, state untouched
  assign cmd.accept = cmd.cmdValid & decWord[6];
  assign cmd.nextState = rosm_state_t'(decWord[5:3]);
  assign cmd.pendState = rosm_state_t'(decWord[2:0]);
endmodule : rosm_cmd_decode

// *** core/rosm_top.sv ***
`include "rosm_params.svh"

module rosm_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // shutdown pin, high means shutdown
  input wire logic shutdownPin,
  // decoded host command from the spi front end
  input wire logic cmdValid,
  input wire rosm_pkg::rosm_cmd_t cmdCode,
  // radio finished its transmit or receive activity
  input wire logic activityDone,
  // pin drivers requested by the rest of the device
  input wire logic spiMisoData,
  input wire logic spiMisoDrive,
  input wire logic [`ROSM_GPIO_N-1:0] gpioData,
  input wire logic [`ROSM_GPIO_N-1:0] gpioDrive,
  // state and power controls
  output rosm_pkg::rosm_state_t opState,
  output logic cfgHold,
  output logic hostAccess,
  output logic crystalOscillatorReferenceOn,
  output logic localOscillatorSignalOn,
  output logic txOn,
  output logic rxOn,
  output logic retainOn,
  // pads
  output logic spiMisoOut,
  output logic spiMisoOe,
  output logic [`ROSM_GPIO_N-1:0] gpioOut,
  output logic [`ROSM_GPIO_N-1:0] gpioOe
);
  import rosm_pkg::*;

  // ==========================================
  // command decode
  rosm_cmd_if cmdBus ();
  rosm_cmd_decode uDecode (
    .cmd(cmdBus.dec)
  );

  rosm_state_t stateReg, stateNext;
  rosm_state_t pendReg, pendNext;
  logic [`ROSM_LOCK_W-1:0] lockCntReg, lockCntNext;

  wire autoLock = (stateReg == ROSM_LOCK) && (pendReg != ROSM_LOCK);
  wire lockDone = autoLock && (lockCntReg == '0);
  wire doneHit = activityDone && ((stateReg == ROSM_TX) || (stateReg == ROSM_RX));
  // commands are held off while the automatic lock step runs
  wire cmdTake = cmdBus.accept && !autoLock;

  assign cmdBus.cmdValid = cmdValid;
  assign cmdBus.cmdCode = cmdCode;
  assign cmdBus.curState = stateReg;

  // ==========================================
  // next state
  assign stateNext = shutdownPin ? ROSM_SHUTDOWN :
                     (stateReg == ROSM_SHUTDOWN) ? ROSM_READY :
                     lockDone ? pendReg :
                     cmdTake ? cmdBus.nextState :
                     doneHit ? ROSM_READY :
                     stateReg;
  assign pendNext = (shutdownPin || lockDone) ? ROSM_LOCK :
                    cmdTake ? cmdBus.pendState : pendReg;
  assign lockCntNext = (cmdTake && cmdBus.pendState != ROSM_LOCK) ?
                       `ROSM_LOCK_W'(`ROSM_LOCK_CYCLES - 1) :
                       (autoLock && lockCntReg != '0) ? lockCntReg - `ROSM_LOCK_W'(1) : lockCntReg;

  wire sdnNext = (stateNext == ROSM_SHUTDOWN);
  wire loNext = (stateNext == ROSM_LOCK) || (stateNext == ROSM_TX) || (stateNext == ROSM_RX);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ROSM_SHUTDOWN;
      pendReg <= ROSM_LOCK;
      lockCntReg <= '0;
    end else begin
      stateReg <= stateNext;
      pendReg <= pendNext;
      lockCntReg <= shutdownPin ? '0 : lockCntNext;
    end
  end

  // ==========================================
  // registered controls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opState <= ROSM_SHUTDOWN;
      cfgHold <= 1'b1;
      hostAccess <= 1'b0;
      crystalOscillatorReferenceOn <= 1'b0;
      localOscillatorSignalOn <= 1'b0;
      txOn <= 1'b0;
      rxOn <= 1'b0;
      retainOn <= 1'b0;
    end else begin
      opState <= stateNext;
      cfgHold <= sdnNext;
      hostAccess <= !sdnNext;
      crystalOscillatorReferenceOn <= !sdnNext;
      localOscillatorSignalOn <= loNext;
      txOn <= (stateNext == ROSM_TX);
      rxOn <= (stateNext == ROSM_RX);
      retainOn <= !sdnNext;
    end
  end

  // ==========================================
  // pads, released only outside shutdown
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spiMisoOut <= 1'b0;
      spiMisoOe <= 1'b0;
    end else begin
      spiMisoOut <= sdnNext ? 1'b0 : spiMisoData;
      spiMisoOe <= !sdnNext && spiMisoDrive;
    end
  end

  for (genvar g = 0; g < `ROSM_GPIO_N; g++) begin : gPad
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        gpioOut[g] <= 1'b0;
        gpioOe[g] <= 1'b0;
      end else begin
        gpioOut[g] <= sdnNext ? 1'b0 : gpioData[g];
        gpioOe[g] <= !sdnNext && gpioDrive[g];
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_sdn_forces_off: assert property (shutdownPin |=> stateReg == ROSM_SHUTDOWN && cfgHold)
    else $error("shutdown pin did not force shutdown");
  a_cfg_hold_sdn: assert property (cfgHold == (stateReg == ROSM_SHUTDOWN) && retainOn == !cfgHold)
    else $error("configuration hold does not follow shutdown");
  a_pins_hiz: assert property (stateReg == ROSM_SHUTDOWN |-> !spiMisoOe && gpioOe == '0)
    else $error("pad driven during shutdown");
  a_release_ready: assert property (stateReg == ROSM_SHUTDOWN && !shutdownPin
    |=> stateReg == ROSM_READY && crystalOscillatorReferenceOn)
    else $error("release did not enter ready with reference on");
  a_lo_active: assert property (localOscillatorSignalOn ==
    (stateReg inside {ROSM_LOCK, ROSM_TX, ROSM_RX}))
    else $error("local oscillator enable mismatch");
  a_no_direct_swap: assert property ((stateReg == ROSM_TX |=> stateReg != ROSM_RX)
    and (stateReg == ROSM_RX |=> stateReg != ROSM_TX))
    else $error("direct switch between transmit and receive");
  // lock holds 100 samples, then transmit; a shutdown in the wait abandons it
  a_tx_auto_lock: assert property (disable iff (!rst_n || shutdownPin)
    stateReg == ROSM_READY && cmdValid && cmdCode == ROSM_CMD_TX
    |=> stateReg == ROSM_LOCK ##100 stateReg == ROSM_TX)
    else $error("transmit not reached after automatic lock");
  a_sleep_via_ready: assert property (stateReg == ROSM_SLEEP && $past(stateReg) != ROSM_SLEEP
    |-> $past(stateReg) == ROSM_READY)
    else $error("sleep entered from other than ready");
  a_standby_ready: assert property (stateReg == ROSM_STANDBY && $past(stateReg) != ROSM_STANDBY
    |-> $past(stateReg) == ROSM_READY)
    else $error("standby entered from other than ready");
  a_change_by_cmd: assert property (!shutdownPin && stateReg inside {ROSM_READY, ROSM_SLEEP, ROSM_STANDBY}
    && !cmdValid |=> $stable(stateReg))
    else $error("state changed without a command");
  a_access_live: assert property (hostAccess == (stateReg != ROSM_SHUTDOWN))
    else $error("host access does not follow shutdown");
  a_bad_cmd_ignored: assert property (!shutdownPin && cmdValid && !cmdBus.accept && !doneHit && !autoLock
    && stateReg != ROSM_SHUTDOWN |=> $stable(stateReg))
    else $error("refused command changed state");

  c_tx_path: cover property (stateReg == ROSM_READY ##1 stateReg == ROSM_LOCK [*8] ##[1:200] stateReg == ROSM_TX);
  c_rx_to_tx: cover property (stateReg == ROSM_RX ##1 stateReg == ROSM_LOCK ##[1:200] stateReg == ROSM_TX);
  c_sleep: cover property (stateReg == ROSM_READY ##1 stateReg == ROSM_SLEEP);
  c_standby: cover property (stateReg == ROSM_READY ##1 stateReg == ROSM_STANDBY);
endmodule : rosm_top

// *** tb/rosm_host_model.sv ***
module rosm_host_model (
  // clock
  input wire logic clk_sys,
  // shutdown pin and decoded commands
  output logic shutdownPin,
  output logic cmdValid,
  output rosm_pkg::rosm_cmd_t cmdCode
);
  timeunit 1ns;
  timeprecision 1ns;
  import rosm_pkg::*;
  // ==========================================
  // host side, called at a falling edge
  initial begin
    shutdownPin = 1'b0;
    cmdValid = 1'b0;
    cmdCode = ROSM_CMD_STANDBY;
  end
  task automatic setPin(input logic v);
    shutdownPin = v;
  endtask : setPin
  // one pulse per request; code scrambled once released
  task automatic sendCmd(input rosm_cmd_t c);
    cmdValid = 1'b1;
    cmdCode = c;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    cmdCode = rosm_cmd_t'(~c);
  endtask : sendCmd
endmodule : rosm_host_model

// *** tb/testbench.sv ***
`include "rosm_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rosm_pkg::*;
  logic clk_sys, rst_n, shutdownPin, cmdValid, activityDone, spiMisoData, spiMisoDrive;
  logic cfgHold, hostAccess, xoOn, loOn, txOn, rxOn, retainOn, spiMisoOut, spiMisoOe;
  logic [`ROSM_GPIO_N-1:0] gpioData, gpioDrive, gpioOut, gpioOe;
  rosm_cmd_t cmdCode;
  rosm_state_t opState;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  rosm_top rosm_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .shutdownPin(shutdownPin), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .activityDone(activityDone), .spiMisoData(spiMisoData), .spiMisoDrive(spiMisoDrive),
    .gpioData(gpioData), .gpioDrive(gpioDrive), .opState(opState), .cfgHold(cfgHold), .hostAccess(hostAccess),
    .crystalOscillatorReferenceOn(xoOn), .localOscillatorSignalOn(loOn), .txOn(txOn), .rxOn(rxOn),
    .retainOn(retainOn), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe), .gpioOut(gpioOut), .gpioOe(gpioOe));
  rosm_host_model rosm_host_model_inst (.clk_sys(clk_sys), .shutdownPin(shutdownPin), .cmdValid(cmdValid),
    .cmdCode(cmdCode));
  // ==========================================
  // clock and timeout
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end
  // ==========================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step
  // controls follow from the state alone
  task automatic expState(input rosm_state_t s);
    logic off;
    off = (s == ROSM_SHUTDOWN);
    check(16'(opState), 16'(s));
    check({cfgHold, hostAccess, xoOn, retainOn}, {off, !off, !off, !off});
    check({loOn, txOn, rxOn}, {s inside {ROSM_LOCK, ROSM_TX, ROSM_RX}, s == ROSM_TX, s == ROSM_RX});
  endtask : expState
  // single command, automatic lock, a stray command in the wait
  task automatic lockTo(input rosm_cmd_t c, input rosm_state_t fin);
    rosm_host_model_inst.sendCmd(c);
    expState(ROSM_LOCK);
    step(1);
    rosm_host_model_inst.sendCmd(ROSM_CMD_READY);
    expState(ROSM_LOCK);
    step(97);
    expState(ROSM_LOCK);
    step(1);
    expState(fin);
  endtask : lockTo
  task automatic cmdExpect(input rosm_cmd_t c, input rosm_state_t s);
    rosm_host_model_inst.sendCmd(c);
    expState(s);
  endtask : cmdExpect
  task automatic pulseDone(input rosm_state_t s);
    activityDone = 1'b1;
    step(1);
    activityDone = 1'b0;
    expState(s);
  endtask : pulseDone
  // ==========================================
  // scenarios
  task automatic testPads;
    spiMisoData = 1'b1;
    spiMisoDrive = 1'b1;
    gpioData = 4'ha;
    gpioDrive = 4'hf;
    step(2);
    check({spiMisoOut, spiMisoOe, gpioOut, gpioOe}, {2'h3, 4'ha, 4'hf});
  endtask : testPads
  task automatic testRadio;
    cmdExpect(ROSM_CMD_READY, ROSM_READY);
    lockTo(ROSM_CMD_TX, ROSM_TX);
    lockTo(ROSM_CMD_RX, ROSM_RX);
    lockTo(ROSM_CMD_TX, ROSM_TX);
    pulseDone(ROSM_READY);
    pulseDone(ROSM_READY);
    cmdExpect(ROSM_CMD_SLEEP, ROSM_SLEEP);
    cmdExpect(ROSM_CMD_TX, ROSM_SLEEP);
    cmdExpect(ROSM_CMD_READY, ROSM_READY);
    cmdExpect(ROSM_CMD_STANDBY, ROSM_STANDBY);
    cmdExpect(ROSM_CMD_LOCK, ROSM_STANDBY);
    cmdExpect(ROSM_CMD_READY, ROSM_READY);
    cmdExpect(ROSM_CMD_LOCK, ROSM_LOCK);
    step(3);
    expState(ROSM_LOCK);
    cmdExpect(ROSM_CMD_TX, ROSM_TX);
    cmdExpect(ROSM_CMD_READY, ROSM_READY);
  endtask : testRadio
  task automatic testShutdown;
    rosm_host_model_inst.sendCmd(ROSM_CMD_TX);
    expState(ROSM_LOCK);
    step(20);
    rosm_host_model_inst.setPin(1'b1);
    step(1);
    expState(ROSM_SHUTDOWN);
    check({spiMisoOut, spiMisoOe, gpioOut, gpioOe}, 10'h000);
    cmdExpect(ROSM_CMD_READY, ROSM_SHUTDOWN);
    rosm_host_model_inst.setPin(1'b0);
    step(1);
    expState(ROSM_READY);
    step(1);
    check({spiMisoOe, gpioOe}, 5'h1f);
    step(100);
    expState(ROSM_READY);
  endtask : testShutdown
  task automatic summarize;
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    rst_n = 1'b0;
    activityDone = 1'b0;
    spiMisoData = 1'b0;
    spiMisoDrive = 1'b0;
    gpioData = 4'h0;
    gpioDrive = 4'h0;
    step(8);
    expState(ROSM_SHUTDOWN);
    rst_n = 1'b1;
    step(1);
    expState(ROSM_READY);
    testPads();
    testRadio();
    testShutdown();
    summarize();
  end
endmodule : testbench
